// *** rtl/lbds_defines.vh ***
`ifndef LBDS_DEFINES_VH
`define LBDS_DEFINES_VH
// register byte offsets
`define LBDS_CTRL_OFF 8'h00
`define LBDS_STAT_OFF 8'h04
`define LBDS_IRQ_STAT_OFF 8'h08
`define LBDS_IRQ_EN_OFF 8'h0c
`define LBDS_IRQ_CLR_OFF 8'h10
`define LBDS_FILT_OFF 8'h14
`define LBDS_HOLD_OFF 8'h18
`define LBDS_DO_OFF 8'h1c
// control fields
`define LBDS_CTRL_ENABLE_BIT 0
`define LBDS_CTRL_RESET 1'b1
// status fields
`define LBDS_ST_BROWNOUT_BIT 0
`define LBDS_ST_HOLD_BIT 1
`define LBDS_ST_DROPOUT_BIT 2
`define LBDS_ST_SOFTSTART_BIT 3
`define LBDS_ST_GATE_BIT 4
`define LBDS_ST_SINK_BIT 5
`define LBDS_ST_BURST_BIT 6
// interrupt event fields
`define LBDS_EV_BO_ENTER_BIT 0
`define LBDS_EV_BO_EXIT_BIT 1
`define LBDS_EV_DO_ENTER_BIT 2
`define LBDS_EV_DO_EXIT_BIT 3
`define LBDS_EV_W 4
// timing in clock cycles at 200 MHz
`define LBDS_FILT_RESET 32'h000f4240
`define LBDS_HOLD_RESET 32'h001e8480
// dropout limit, 5 ms
`define LBDS_DO_RESET 32'h000f4240
`define LBDS_TMR_W 32
`endif

// *** rtl/lbds_supervisor.v ***
// What this block does
// - after line sense stays under threshold for the filter time, declare brownout, gates off.
// - during brownout pull the compensation node low and hold the soft-start condition.
// - when line sense is above threshold again, restart through a controlled soft-start ramp.
// - brownout detection, threshold and hysteresis all work on the peak of the line sense.
// - the hysteresis sink is on whenever brownout protection is active, and off otherwise.
// - entering brownout starts a hold timer that forces brownout regardless of the line sense.
// - after the hold time, leave brownout only when the line sense is above threshold; the code also leaves it when the enable bit is cleared.
// - in burst mode the brownout management is powered down.
// - each burst-mode switching stop resets the brownout filter timer.
// - line sense under the detect level for over 5 ms declares dropout and stops the error amp.
// - during dropout apply the small pull-down on the compensation node.
// - cancel dropout and resume the error amp when line sense rises above the clear level.
// - any fault latches soft-start, which waits for comp discharged and fault cleared.
//
// Our own choices: the register addresses and register access over Wishbone.
`include "lbds_defines.vh"
module lbds_supervisor
(
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire bo_above_thr_i,
  input wire do_below_det_i,
  input wire do_above_clr_i,
  input wire burst_stop_i,
  input wire fault_i,
  input wire comp_low_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg gate_en_o,
  output reg comp_pull_low_o,
  output reg soft_start_o,
  output reg brownout_hyst_sink_o,
  output reg ea_enable_o,
  output reg comp_gentle_pd_o,
  output reg irq_o
);
  localparam ST_RUN = 3'b001;
  localparam ST_HOLD = 3'b010;
  localparam ST_BO = 3'b100;

  wire bo_above;
  wire do_below;
  wire do_above;
  wire burst_stop;
  wire fault_s;
  wire comp_low;

  reg [2:0] bo_state_reg;
  reg [2:0] bo_state_next;
  reg [`LBDS_TMR_W-1:0] filt_cnt_reg;
  reg [`LBDS_TMR_W-1:0] hold_cnt_reg;
  reg [`LBDS_TMR_W-1:0] do_cnt_reg;
  reg dropout_reg;
  reg ss_latch_reg;
  reg ctrl_en_reg;
  // programmable limits; the dropout one resets to 5 ms at 200 MHz
  reg [`LBDS_TMR_W-1:0] filt_lim_reg;
  reg [`LBDS_TMR_W-1:0] hold_lim_reg;
  reg [`LBDS_TMR_W-1:0] do_lim_reg;
  reg [`LBDS_EV_W-1:0] irq_stat_reg;
  reg [`LBDS_EV_W-1:0] irq_en_reg;
  reg [`LBDS_EV_W-1:0] ev;
  reg [31:0] rd_data;
  wire bo_active;
  wire wb_req;

  ////////////////////////////////////////////////////////////////////
  // pin inputs all arrive from analog comparators, so synchronise
  // the three-flop chains plus the output flop add four cycles of latency to every comparator
  lbds_sync u_sync_bo (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .d_i(bo_above_thr_i), .q_o(bo_above));
  lbds_sync u_sync_dod (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .d_i(do_below_det_i), .q_o(do_below));
  lbds_sync u_sync_doc (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .d_i(do_above_clr_i), .q_o(do_above));
  lbds_sync u_sync_bst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .d_i(burst_stop_i), .q_o(burst_stop));
  lbds_sync u_sync_flt (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .d_i(fault_i), .q_o(fault_s));
  lbds_sync u_sync_cmp (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .d_i(comp_low_i), .q_o(comp_low));

  ////////////////////////////////////////////////////////////////////
  // brownout state machine
  // the comparator watches the peak-held line sense, so a dip between
  // peaks never clears the filter by itself
  always @*
  begin
    bo_state_next = bo_state_reg;
    case (bo_state_reg)
      ST_RUN:
      begin
        // the filter only counts while enabled and not bursting
        if (ctrl_en_reg && !burst_stop && !bo_above &&
            filt_cnt_reg >= filt_lim_reg - 1'b1)
          bo_state_next = ST_HOLD;
      end
      ST_HOLD:
      begin
        if (hold_cnt_reg >= hold_lim_reg - 1'b1)
          bo_state_next = ST_BO;
      end
      ST_BO:
      begin
        if (bo_above || !ctrl_en_reg)
          bo_state_next = ST_RUN;
      end
      default: bo_state_next = ST_RUN;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      bo_state_reg <= ST_RUN;
    else if (ce_i)
      bo_state_reg <= bo_state_next;
  end

  assign bo_active = (bo_state_reg != ST_RUN);

  ////////////////////////////////////////////////////////////////////
  // brownout filter and hold timers
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      filt_cnt_reg <= {`LBDS_TMR_W{1'b0}};
      hold_cnt_reg <= {`LBDS_TMR_W{1'b0}};
    end
    else if (ce_i)
    begin
      // burst mode powers the filter down and restarts it
      if (bo_above || burst_stop || !ctrl_en_reg || bo_active)
        filt_cnt_reg <= {`LBDS_TMR_W{1'b0}};
      else if (filt_cnt_reg != {`LBDS_TMR_W{1'b1}})
        filt_cnt_reg <= filt_cnt_reg + 1'b1;
      if (bo_state_reg == ST_HOLD)
        hold_cnt_reg <= hold_cnt_reg + 1'b1;
      else
        hold_cnt_reg <= {`LBDS_TMR_W{1'b0}};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // dropout timer; saturates so a long dip cannot wrap and re-arm
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      do_cnt_reg <= {`LBDS_TMR_W{1'b0}};
      dropout_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!do_below)
        do_cnt_reg <= {`LBDS_TMR_W{1'b0}};
      else if (do_cnt_reg != {`LBDS_TMR_W{1'b1}})
        do_cnt_reg <= do_cnt_reg + 1'b1;
      // limit is a register so a bench need not wait the full 5 ms
      if (dropout_reg && do_above)
        dropout_reg <= 1'b0;
      else if (do_below && do_cnt_reg >= do_lim_reg)
        dropout_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // soft-start latch: even a brief fault sticks until comp is
  // discharged and the cause has gone
  always @(posedge clk_i)
  begin
    if (rst_i)
      ss_latch_reg <= 1'b1;
    else if (ce_i)
    begin
      // a brownout re-arms the latch on every cycle it lasts
      if (fault_s || bo_active)
        ss_latch_reg <= 1'b1;
      else if (comp_low)
        ss_latch_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs, all registered
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gate_en_o <= 1'b0;
      comp_pull_low_o <= 1'b1;
      soft_start_o <= 1'b0;
      brownout_hyst_sink_o <= 1'b0;
      ea_enable_o <= 1'b0;
      comp_gentle_pd_o <= 1'b0;
    end
    else if (ce_i)
    begin
      // gates stay off for the whole hold, whatever the line does
      gate_en_o <= !bo_active && !fault_s;
      comp_pull_low_o <= bo_active || fault_s || (ss_latch_reg && !comp_low);
      // soft-start ramp only while the latch is still set and comp is discharged
      soft_start_o <= ss_latch_reg && comp_low && !bo_active && !fault_s;
      brownout_hyst_sink_o <= bo_active;
      ea_enable_o <= !dropout_reg && !bo_active;
      comp_gentle_pd_o <= dropout_reg && !bo_active;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt events: brownout and dropout edges
  always @*
  begin
    ev = {`LBDS_EV_W{1'b0}};
    ev[`LBDS_EV_BO_ENTER_BIT] = (bo_state_reg == ST_RUN) && (bo_state_next == ST_HOLD);
    ev[`LBDS_EV_BO_EXIT_BIT] = (bo_state_reg == ST_BO) && (bo_state_next == ST_RUN);
    ev[`LBDS_EV_DO_ENTER_BIT] = !dropout_reg && do_below && do_cnt_reg >= do_lim_reg;
    ev[`LBDS_EV_DO_EXIT_BIT] = dropout_reg && do_above;
  end

  ////////////////////////////////////////////////////////////////////
  // wishbone classic slave, one wait state, ack drops after one cycle
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always @*
  begin
    rd_data = 32'h00000000;
    if (wb_adr_i[7:0] == `LBDS_CTRL_OFF)
      rd_data[`LBDS_CTRL_ENABLE_BIT] = ctrl_en_reg;
    else if (wb_adr_i[7:0] == `LBDS_STAT_OFF)
    begin
      rd_data[`LBDS_ST_BROWNOUT_BIT] = bo_active;
      rd_data[`LBDS_ST_HOLD_BIT] = (bo_state_reg == ST_HOLD);
      rd_data[`LBDS_ST_DROPOUT_BIT] = dropout_reg;
      rd_data[`LBDS_ST_SOFTSTART_BIT] = ss_latch_reg;
      rd_data[`LBDS_ST_GATE_BIT] = gate_en_o;
      rd_data[`LBDS_ST_SINK_BIT] = brownout_hyst_sink_o;
      rd_data[`LBDS_ST_BURST_BIT] = burst_stop;
    end
    else if (wb_adr_i[7:0] == `LBDS_IRQ_STAT_OFF)
      rd_data[`LBDS_EV_W-1:0] = irq_stat_reg;
    else if (wb_adr_i[7:0] == `LBDS_IRQ_EN_OFF)
      rd_data[`LBDS_EV_W-1:0] = irq_en_reg;
    else if (wb_adr_i[7:0] == `LBDS_FILT_OFF)
      rd_data = filt_lim_reg;
    else if (wb_adr_i[7:0] == `LBDS_HOLD_OFF)
      rd_data = hold_lim_reg;
    // limits read back as whole words
    else if (wb_adr_i[7:0] == `LBDS_DO_OFF)
      rd_data = do_lim_reg;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_en_reg <= `LBDS_CTRL_RESET;
      filt_lim_reg <= `LBDS_FILT_RESET;
      hold_lim_reg <= `LBDS_HOLD_RESET;
      do_lim_reg <= `LBDS_DO_RESET;
      irq_en_reg <= {`LBDS_EV_W{1'b0}};
      irq_stat_reg <= {`LBDS_EV_W{1'b0}};
      irq_o <= 1'b0;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? rd_data : 32'h00000000;
      // clear first, then set, so an event in the clear cycle survives
      if (wb_req && wb_we_i && wb_adr_i[7:0] == `LBDS_IRQ_CLR_OFF && wb_sel_i[0])
        irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[`LBDS_EV_W-1:0]) | ev;
      else
        irq_stat_reg <= irq_stat_reg | ev;
      // looks ahead at this cycle's events so irq rises with the status bit
      irq_o <= |((irq_stat_reg | ev) & irq_en_reg);
      if (wb_req && wb_we_i)
      begin
        if (wb_adr_i[7:0] == `LBDS_CTRL_OFF && wb_sel_i[0])
          ctrl_en_reg <= wb_dat_i[`LBDS_CTRL_ENABLE_BIT];
        else if (wb_adr_i[7:0] == `LBDS_IRQ_EN_OFF && wb_sel_i[0])
          irq_en_reg <= wb_dat_i[`LBDS_EV_W-1:0];
        else if (wb_adr_i[7:0] == `LBDS_FILT_OFF && wb_sel_i == 4'hf)
          filt_lim_reg <= wb_dat_i;
        else if (wb_adr_i[7:0] == `LBDS_HOLD_OFF && wb_sel_i == 4'hf)
          hold_lim_reg <= wb_dat_i;
        // every limit wants all four lanes, so a byte write cannot tear a count
        else if (wb_adr_i[7:0] == `LBDS_DO_OFF && wb_sel_i == 4'hf)
          do_lim_reg <= wb_dat_i;
      end
    end
  end
endmodule

// *** rtl/lbds_sync.v ***
// three-stage synchroniser; output moves once stages two and three agree
module lbds_sync
(
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire d_i,
  output reg q_o
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // first stage is read only by the second
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q_o <= 1'b0;
    end
    else if (ce_i)
    begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        q_o <= s3_reg;
    end
  end
endmodule

// *** verif/lbds_line_model.sv ***
module lbds_line_model
(
  input wire clk_i,
  input wire [1:0] lvl_i,
  input wire pull_i,
  input wire pd_i,
  input wire ramp_i,
  output wire bo_above_o,
  output wire do_below_o,
  output wire do_above_o,
  output wire comp_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] comp_v = 4'h8;
  // line level 0 dropout, 1 below threshold, 2 healthy; peak-based compare
  assign bo_above_o = (lvl_i == 2'h2);
  assign do_below_o = (lvl_i == 2'h0);
  assign do_above_o = (lvl_i != 2'h0);
  // comp node: starts charged so reset must really discharge it first
  always @(posedge clk_i)
  begin
    if ((pull_i || pd_i) && comp_v != 4'h0)
      comp_v <= comp_v - 4'h1;
    else if (ramp_i && !pull_i && comp_v != 4'hf)
      comp_v <= comp_v + 4'h1;
  end
  assign comp_low_o = (comp_v == 4'h0);
endmodule

// *** verif/lbds_props.sv ***
module lbds_props
(
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire bo_above_thr_i,
  input wire burst_stop_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire gate_en_o,
  input wire comp_pull_low_o,
  input wire brownout_hyst_sink_o,
  input wire ea_enable_o,
  input wire comp_gentle_pd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a low clock enable freezes state, so it masks checks like reset does
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);
  //////////////////////////////////////////////////////////////////////////////
  // brownout and dropout outputs
  AST_BO_GATE_OFF: assert property (brownout_hyst_sink_o |-> !gate_en_o)
    else $error("gate enabled while sink on");
  AST_BO_PULL_LOW: assert property ($rose(brownout_hyst_sink_o) |-> comp_pull_low_o)
    else $error("comp not pulled low at brownout entry");
  AST_BO_HOLD: assert property ($rose(brownout_hyst_sink_o) |-> brownout_hyst_sink_o[*8])
    else $error("brownout left before hold time");
  AST_BURST_NO_BO: assert property (burst_stop_i[*8] |-> !$rose(brownout_hyst_sink_o))
    else $error("brownout declared while bursting");
  AST_ABOVE_NO_BO: assert property (bo_above_thr_i[*8] |-> !$rose(brownout_hyst_sink_o))
    else $error("brownout declared with line above threshold");
  AST_DO_EA_OFF: assert property (comp_gentle_pd_o |-> !ea_enable_o)
    else $error("gentle pull-down with error amp active");
  //////////////////////////////////////////////////////////////////////////////
  // register bus handshake
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack cycle");
endmodule
bind lbds_supervisor lbds_props u_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .bo_above_thr_i(bo_above_thr_i), .burst_stop_i(burst_stop_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .gate_en_o(gate_en_o),
  .comp_pull_low_o(comp_pull_low_o), .brownout_hyst_sink_o(brownout_hyst_sink_o),
  .ea_enable_o(ea_enable_o), .comp_gentle_pd_o(comp_gentle_pd_o));

// *** verif/lbds_supervisor_test.sv ***
`include "lbds_defines.vh"
module lbds_supervisor_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FILT = 20;
  localparam int HOLD = 20;
  localparam int DOLIM = 30;
  logic clk_i = 0, rst_i = 1, ce = 1, burst = 0, fault = 0, we = 0, cyc = 0, stb = 0;
  logic [1:0] lvl = 2'h2;
  logic [31:0] adr = 32'h0, wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [32:0] expq[$];
  logic [32:0] q;
  wire [31:0] rdat;
  wire ack, gate, pull, ramp, sink, ea, gpd, irq, bo_a, do_b, do_a, cl;
  int error_cnt = 0, n_tests = 0, cyc_cnt = 0;
  lbds_supervisor uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .bo_above_thr_i(bo_a),
    .do_below_det_i(do_b), .do_above_clr_i(do_a), .burst_stop_i(burst), .fault_i(fault),
    .comp_low_i(cl), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .gate_en_o(gate),
    .comp_pull_low_o(pull), .soft_start_o(ramp), .brownout_hyst_sink_o(sink),
    .ea_enable_o(ea), .comp_gentle_pd_o(gpd), .irq_o(irq));
  lbds_line_model u_line (.clk_i(clk_i), .lvl_i(lvl), .pull_i(pull), .pd_i(gpd),
    .ramp_i(ramp), .bo_above_o(bo_a), .do_below_o(do_b), .do_above_o(do_a), .comp_low_o(cl));
  initial forever #2.5 clk_i = ~clk_i;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // classic single cycle; read noted with flag so the monitor compares it
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    expq.push_back({!w, d});
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    sel <= 4'hf;
    adr <= {24'h0, a};
    wdat <= w ? d : $urandom;
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  // 0 sink, 1 soft-start, 2 gate, 3 error amp; gives up after a bounded wait
  task automatic wait_on(input int w, input logic v);
    for (int i = 0; i < 400; i++)
    begin
      @(posedge clk_i);
      if ((w == 0 ? sink : w == 1 ? ramp : w == 2 ? gate : ea) === v)
        break;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // monitor: oldest note taken whenever an ack shows
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      error_cnt++;
      end_sim();
    end
    if (ack === 1'b1)
    begin
      q = expq.pop_front();
      if (q[32])
        chk(rdat, q[31:0]);
    end
  end
  initial
  begin
    void'($urandom(43));
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    bus(0, `LBDS_CTRL_OFF, 32'h1);
    bus(0, `LBDS_FILT_OFF, `LBDS_FILT_RESET);
    bus(0, `LBDS_HOLD_OFF, `LBDS_HOLD_RESET);
    bus(0, `LBDS_DO_OFF, `LBDS_DO_RESET);
    bus(1, 8'h40, 32'hffffffff);
    bus(0, 8'h40, 32'h0);
    bus(1, `LBDS_FILT_OFF, FILT);
    bus(1, `LBDS_HOLD_OFF, HOLD);
    bus(1, `LBDS_IRQ_EN_OFF, 32'h1);
    wait_on(2, 1);
    chk(gate, 1);
    bus(0, `LBDS_STAT_OFF, 32'h10);
    $display("registers and start-up done");
    lvl <= 2'h1;
    wait_on(0, 1);
    chk(sink, 1);
    chk(gate, 0);
    chk(pull, 1);
    lvl <= 2'h2;
    repeat (HOLD / 2) @(posedge clk_i);
    chk({sink, gate}, 2'b10);
    wait_on(1, 1);
    chk(sink, 0);
    chk(ramp, 1);
    wait_on(2, 1);
    chk(gate, 1);
    chk(irq, 1);
    bus(0, `LBDS_IRQ_STAT_OFF, 32'h3);
    bus(1, `LBDS_IRQ_CLR_OFF, 32'hf);
    repeat (2) @(posedge clk_i);
    chk(irq, 0);
    bus(0, `LBDS_IRQ_STAT_OFF, 32'h0);
    $display("brownout entry and exit done");
    lvl <= 2'h1;
    wait_on(0, 1);
    repeat (3 * HOLD) @(posedge clk_i);
    chk(sink, 1);
    lvl <= 2'h2;
    wait_on(0, 0);
    chk(sink, 0);
    $display("held brownout done");
    repeat (3)
    begin
      burst <= 1;
      lvl <= 2'h1;
      repeat (FILT + 5 + $urandom % 40) @(posedge clk_i);
      chk(sink, 0);
      burst <= 0;
      lvl <= 2'h2;
      repeat (6) @(posedge clk_i);
    end
    repeat (4)
    begin
      lvl <= 2'h1;
      repeat (FILT - 6) @(posedge clk_i);
      lvl <= 2'h2;
      repeat (8) @(posedge clk_i);
    end
    chk(sink, 0);
    $display("burst and filter restart done");
    fault <= 1;
    wait_on(2, 0);
    chk(pull, 1);
    fault <= 0;
    wait_on(1, 1);
    chk({ramp, gate, sink}, 3'b110);
    $display("fault soft-start done");
    // burst holds the brownout filter cleared so only dropout acts
    bus(1, `LBDS_DO_OFF, DOLIM);
    burst <= 1;
    lvl <= 2'h0;
    wait_on(3, 0);
    chk({ea, gpd, sink}, 3'b010);
    bus(0, `LBDS_IRQ_STAT_OFF, 32'h7);
    lvl <= 2'h1;
    wait_on(3, 1);
    chk({ea, gpd}, 2'b10);
    burst <= 0;
    lvl <= 2'h2;
    repeat (8) @(posedge clk_i);
    $display("dropout done");
    end_sim();
  end
endmodule
